// [logic/tdc_conditioner.sv]
// Classifier, token-bucket meter, marker, shaper and dropper for one
// descriptor stream. Assumes descriptors come from logic on hclk and a
// single AHB-Lite master with zero-wait answers.
`timescale 1ns/1ps
`default_nettype none
module tdc_conditioner #(
  parameter int BUF_DEPTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_tag,
  input wire logic [15:0] in_len,
  input wire logic [7:0] in_ds,
  input wire logic [31:0] in_src,
  input wire logic [31:0] in_dst,
  input wire logic [7:0] in_proto,
  input wire logic [15:0] in_sport,
  input wire logic [15:0] in_dport,
  input wire logic [3:0] in_iface,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_tag,
  output logic [15:0] out_len,
  output logic [7:0] out_ds,
  output tdc_pkg::tdc_grade_t out_grade,
  output logic out_cond
);
  import tdc_pkg::*;

  localparam int CW = $clog2(BUF_DEPTH + 1);

  typedef struct packed {
    logic [15:0] tag;
    logic [15:0] len;
    logic [7:0] ds;
  } tdc_ent_t;

  typedef struct packed {
    logic ph_act;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] ctrl;
    logic [31:0] rate;
    logic [31:0] burst;
    logic [31:0] mark;
    logic [63:0] map;
    logic [31:0] hdr_src;
    logic [31:0] hdr_dst;
    logic [31:0] hdr_ports;
    logic [31:0] hdr_misc;
    logic [2:0] irq;
    logic [2:0] mask;
    logic [23:0] tokens;
    logic [CW-1:0] cnt;
    tdc_ent_t [BUF_DEPTH-1:0] buf_q;
    logic ov;
    tdc_ent_t oe;
    tdc_grade_t og;
    logic oc;
  } tdc_state_t;

  tdc_state_t s;
  tdc_state_t next_s;

  // Marker code for a grade: fixed or chosen from the configured set
  function automatic logic [5:0] sel_code(input logic [31:0] mark, input logic by_grade, input tdc_grade_t g);
    if (!by_grade) return mark[5:0];
    unique case (g)
      TDC_GR_IN: return mark[13:8];
      TDC_GR_MID: return mark[29:24];
      default: return mark[21:16];
    endcase
  endfunction : sel_code

  // Register read decode
  function automatic logic [31:0] rd_reg(input tdc_state_t st, input logic [7:0] a);
    unique case (a)
      TDC_CTRL: return st.ctrl;
      TDC_RATE: return st.rate;
      TDC_BURST: return st.burst;
      TDC_MARK: return st.mark;
      TDC_MAP_LO: return st.map[31:0];
      TDC_MAP_HI: return st.map[63:32];
      TDC_HDR_SRC: return st.hdr_src;
      TDC_HDR_DST: return st.hdr_dst;
      TDC_HDR_PORTS: return st.hdr_ports;
      TDC_HDR_MISC: return st.hdr_misc;
      TDC_STATUS: return {4'h0, 4'(st.cnt), st.tokens};
      TDC_IRQ_STAT: return {29'h0000_0000, st.irq};
      TDC_IRQ_MASK: return {29'h0000_0000, st.mask};
      default: return 32'h0000_0000;
    endcase
  endfunction : rd_reg

  logic take;
  logic hdr_hit;
  logic cls_cond;
  logic meter_on;
  logic [5:0] cp;
  logic [5:0] keep_cp;
  logic [24:0] tok_sum;
  logic [23:0] tok_fill;
  tdc_grade_t grade;
  tdc_act_t act;
  logic [CW-1:0] cap;
  logic to_shape;
  logic rel;
  logic [2:0] irq_set;
  logic [7:0] en;

  ////////////////////////////////////////////////////////////////////////
  // Bus answers and stream handshake
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = (s.ph_act && !s.ph_wr) ? rd_reg(s, s.ph_addr) : 32'h0000_0000;
  assign irq = |(s.irq & s.mask);
  assign in_ready = !s.ov || out_ready;
  assign take = in_valid && in_ready;
  assign out_valid = s.ov;
  assign out_tag = s.oe.tag;
  assign out_len = s.oe.len;
  assign out_ds = s.oe.ds;
  assign out_grade = s.og;
  assign out_cond = s.oc;

  ////////////////////////////////////////////////////////////////////////
  // Classification, metering and marking decisions
  always_comb begin
    cp = in_ds[7:2];
    en = s.hdr_misc[MISC_EN+:8];
    // Fields enabled in the loaded rule must all match
    hdr_hit = (!en[0] || in_src == s.hdr_src) && (!en[1] || in_dst == s.hdr_dst)
      && (!en[2] || cp == s.hdr_misc[21:16]) && (!en[3] || in_proto == s.hdr_misc[7:0])
      && (!en[4] || in_sport == s.hdr_ports[31:16]) && (!en[5] || in_dport == s.hdr_ports[15:0])
      && (!en[6] || in_iface == s.hdr_misc[11:8]);
    // Steering decision: header rule match, or the map bit of the codepoint the upstream marked
    cls_cond = s.ctrl[CTRL_HDR] ? hdr_hit : s.map[cp];
    keep_cp = s.map[cp] ? cp : TDC_DSCP_DEFAULT;
    meter_on = s.ctrl[CTRL_METER];
    tok_sum = {1'b0, s.tokens} + {1'b0, s.rate[23:0]};
    tok_fill = (tok_sum > {1'b0, s.burst[23:0]}) ? s.burst[23:0] : tok_sum[23:0];
    if ({8'h00, in_len} <= tok_fill) grade = TDC_GR_IN;
    else if (s.ctrl[CTRL_MULTI] && {9'h000, in_len[15:1]} <= tok_fill) grade = TDC_GR_MID;
    else grade = TDC_GR_OUT;
    act = tdc_act_t'(s.ctrl[CTRL_ACT+:2]);
    cap = (s.ctrl[CTRL_CAP+:4] > 4'(BUF_DEPTH)) ? CW'(BUF_DEPTH) : CW'(s.ctrl[CTRL_CAP+:4]);
    to_shape = take && cls_cond && meter_on && grade != TDC_GR_IN && act == TDC_ACT_SHAPE;
    // Release the head only when no new packet competes for the output
    rel = s.cnt != '0 && !take && in_ready && {8'h00, s.buf_q[0].len} <= tok_fill;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    irq_set = 3'h0;
    // Address phase capture
    if (hready) begin
      next_s.ph_act = hsel && htrans[1];
      next_s.ph_wr = hwrite;
      next_s.ph_addr = {haddr[7:2], 2'b00};
    end
    // Data phase write
    if (s.ph_act && s.ph_wr) begin
      unique case (s.ph_addr)
        TDC_CTRL: next_s.ctrl = hwdata;
        TDC_RATE: next_s.rate = hwdata;
        TDC_BURST: next_s.burst = hwdata;
        TDC_MARK: next_s.mark = hwdata;
        TDC_MAP_LO: next_s.map[31:0] = hwdata;
        TDC_MAP_HI: next_s.map[63:32] = hwdata;
        TDC_HDR_SRC: next_s.hdr_src = hwdata;
        TDC_HDR_DST: next_s.hdr_dst = hwdata;
        TDC_HDR_PORTS: next_s.hdr_ports = hwdata;
        TDC_HDR_MISC: next_s.hdr_misc = hwdata;
        TDC_IRQ_MASK: next_s.mask = hwdata[2:0];
        default: ;
      endcase
    end
    // Bucket fill, then deduct what leaves in profile
    next_s.tokens = tok_fill;
    if (s.ov && out_ready) next_s.ov = 1'b0;
    if (take) begin
      next_s.oe.tag = in_tag;
      next_s.oe.len = in_len;
      next_s.og = meter_on ? grade : TDC_GR_IN;
      next_s.oc = cls_cond;
      next_s.ov = 1'b1;
      if (!cls_cond) begin
        next_s.oe.ds = {keep_cp, in_ds[1:0]};
      end else if (!meter_on) begin
        next_s.oe.ds = {sel_code(s.mark, s.ctrl[CTRL_MKSEL], TDC_GR_IN), in_ds[1:0]};
      end else if (grade == TDC_GR_IN) begin
        next_s.tokens = tok_fill - {8'h00, in_len};
        next_s.oe.ds = {s.ctrl[CTRL_INREM] ? sel_code(s.mark, s.ctrl[CTRL_MKSEL], grade) : keep_cp,
          in_ds[1:0]};
      end else begin
        unique case (act)
          TDC_ACT_SHAPE: begin
            next_s.ov = 1'b0;
            if (s.cnt < cap) begin
              next_s.buf_q[s.cnt[$clog2(BUF_DEPTH)-1:0]].tag = in_tag;
              next_s.buf_q[s.cnt[$clog2(BUF_DEPTH)-1:0]].len = in_len;
              next_s.buf_q[s.cnt[$clog2(BUF_DEPTH)-1:0]].ds = {s.ctrl[CTRL_INREM] ?
                sel_code(s.mark, s.ctrl[CTRL_MKSEL], TDC_GR_IN) : keep_cp, in_ds[1:0]};
              next_s.cnt = s.cnt + 1'b1;
            end else begin
              irq_set[IRQ_SDROP] = 1'b1;
            end
          end
          TDC_ACT_DROP: begin
            next_s.ov = 1'b0;
            irq_set[IRQ_PDROP] = 1'b1;
          end
          TDC_ACT_REMARK: begin
            next_s.oe.ds = {sel_code(s.mark, s.ctrl[CTRL_MKSEL], grade), in_ds[1:0]};
          end
          TDC_ACT_PASS: begin
            next_s.oe.ds = {keep_cp, in_ds[1:0]};
            irq_set[IRQ_ACCT] = 1'b1;
          end
        endcase
      end
    end else if (rel) begin
      // Shaped packet now conforms: spend its tokens and send it
      next_s.tokens = tok_fill - {8'h00, s.buf_q[0].len};
      next_s.oe = s.buf_q[0];
      next_s.og = TDC_GR_IN;
      next_s.oc = 1'b1;
      next_s.ov = 1'b1;
      for (int i = 0; i < BUF_DEPTH - 1; i++) next_s.buf_q[i] = s.buf_q[i+1];
      next_s.cnt = s.cnt - 1'b1;
    end
    // Sticky flags: a new event wins over a write-one clear
    next_s.irq = s.irq;
    if (s.ph_act && s.ph_wr && s.ph_addr == TDC_IRQ_STAT) next_s.irq = s.irq & ~hwdata[2:0];
    next_s.irq = (next_s.irq | irq_set) & IRQ_USED;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ba_path;
    take && !s.ctrl[CTRL_HDR] |-> cls_cond == s.map[in_ds[7:2]];
  endproperty
  a_ba_path: assert property (p_ba_path) else $error("BA path not from codepoint");

  property p_hdr_open;
    take && s.ctrl[CTRL_HDR] && s.hdr_misc[MISC_EN+:7] == 7'h00 |=> out_cond || s.irq != 3'h0 || s.cnt != '0;
  endproperty
  a_hdr_open: assert property (p_hdr_open) else $error("Empty header rule did not steer");

  property p_out_grade;
    take && cls_cond && meter_on && !s.ctrl[CTRL_MULTI] && {8'h00, in_len} > tok_fill |-> grade == TDC_GR_OUT;
  endproperty
  a_out_grade: assert property (p_out_grade) else $error("Short bucket not out of profile");

  property p_deduct;
    take && cls_cond && meter_on && grade == TDC_GR_IN |=> s.tokens == $past(tok_fill) - {8'h00, $past(in_len)};
  endproperty
  a_deduct: assert property (p_deduct) else $error("Bucket not deducted");

  property p_sat;
    $stable(s.burst) |-> s.tokens <= s.burst[23:0];
  endproperty
  a_sat: assert property (p_sat) else $error("Bucket above burst");

  property p_full_drop;
    to_shape && s.cnt >= cap |=> s.irq[IRQ_SDROP] && s.cnt == $past(s.cnt);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("Full shaper accepted");

  property p_police;
    take && cls_cond && meter_on && grade != TDC_GR_IN && act == TDC_ACT_DROP |=> s.irq[IRQ_PDROP] && !s.ov;
  endproperty
  a_police: assert property (p_police) else $error("Policed packet not dropped");

  property p_low_bits;
    take && (!cls_cond || !meter_on || grade == TDC_GR_IN || act[1]) |=> out_valid && out_ds[1:0] == $past(in_ds[1:0]);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("Low DS bits changed");

  property p_no_profile;
    take && cls_cond && !meter_on && !s.ctrl[CTRL_MKSEL] |=> out_valid && out_ds[7:2] == $past(s.mark[5:0]);
  endproperty
  a_no_profile: assert property (p_no_profile) else $error("Marker only path wrong");

  property p_default;
    take && !cls_cond && !s.map[in_ds[7:2]] |=> out_ds[7:2] == TDC_DSCP_DEFAULT;
  endproperty
  a_default: assert property (p_default) else $error("Unmapped code kept");

  c_release: cover property (rel);
  c_mid: cover property (take && meter_on && grade == TDC_GR_MID);
  c_sdrop: cover property (s.irq[IRQ_SDROP]);
endmodule : tdc_conditioner
`default_nettype wire

// [logic/tdc_pkg.sv]
// Constants and types shared by the traffic conditioner.
// Assumes a 32-bit AHB-Lite register bus and a word-aligned map.
package tdc_pkg;
  // Register byte offsets
  localparam logic [7:0] TDC_CTRL = 8'h00;
  localparam logic [7:0] TDC_RATE = 8'h04;
  localparam logic [7:0] TDC_BURST = 8'h08;
  localparam logic [7:0] TDC_MARK = 8'h0c;
  localparam logic [7:0] TDC_MAP_LO = 8'h10;
  localparam logic [7:0] TDC_MAP_HI = 8'h14;
  localparam logic [7:0] TDC_HDR_SRC = 8'h18;
  localparam logic [7:0] TDC_HDR_DST = 8'h1c;
  localparam logic [7:0] TDC_HDR_PORTS = 8'h20;
  localparam logic [7:0] TDC_HDR_MISC = 8'h24;
  localparam logic [7:0] TDC_STATUS = 8'h28;
  localparam logic [7:0] TDC_IRQ_STAT = 8'h2c;
  localparam logic [7:0] TDC_IRQ_MASK = 8'h30;
  // Control fields
  localparam int CTRL_HDR = 0;
  localparam int CTRL_METER = 1;
  localparam int CTRL_MULTI = 2;
  localparam int CTRL_ACT = 4;
  localparam int CTRL_INREM = 6;
  localparam int CTRL_MKSEL = 7;
  localparam int CTRL_CAP = 8;
  // Match field enables in the misc register
  localparam int MISC_EN = 24;
  // Interrupt status bits
  localparam int IRQ_ACCT = 0;
  localparam int IRQ_SDROP = 1;
  localparam int IRQ_PDROP = 2;
  localparam logic [2:0] IRQ_USED = 3'h7;
  // Reset values
  localparam logic [31:0] TDC_REG_RST = 32'h0000_0000;
  localparam logic [5:0] TDC_DSCP_DEFAULT = 6'h00;
  // Out-of-profile actions
  typedef enum logic [1:0] {
    TDC_ACT_SHAPE = 2'b00,
    TDC_ACT_DROP = 2'b01,
    TDC_ACT_REMARK = 2'b10,
    TDC_ACT_PASS = 2'b11
  } tdc_act_t;
  // Conformance grades
  typedef enum logic [1:0] {
    TDC_GR_IN = 2'b00,
    TDC_GR_MID = 2'b01,
    TDC_GR_OUT = 2'b10
  } tdc_grade_t;
endpackage : tdc_pkg

// [tb/diffserv_traffic_conditioner_tb_top.sv]
// Self-checking bench for the traffic conditioner.
// Assumes an AHB-Lite master, a descriptor source and the sink model.
`timescale 1ns/1ps
`default_nettype none
module diffserv_traffic_conditioner_tb_top;
  import tdc_pkg::*;
  localparam logic [10:0] ALL = 11'h7ff;
  localparam logic [10:0] NOG = 11'h4ff;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, in_valid = 0, stall = 0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd_n;
  logic [15:0] in_tag = 16'h0000, in_len = 16'h0000;
  logic [7:0] in_ds = 8'h00, in_proto = 8'h00;
  logic [3:0] in_iface = 4'h0;
  logic hreadyout, hresp, irq, in_ready, out_valid, out_ready, out_cond, rdy_n, ir_n;
  logic [31:0] hrdata;
  logic [15:0] out_tag, out_len, rx_tag;
  logic [7:0] out_ds;
  logic [10:0] rx_got;
  tdc_grade_t out_grade;
  int rx_count, failures = 0, samples_checked = 0, cyc = 0;
  tdc_conditioner #(.BUF_DEPTH(4)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .in_valid(in_valid), .in_ready(in_ready), .in_tag(in_tag), .in_len(in_len), .in_ds(in_ds),
    .in_src(32'h0a00_0001), .in_dst(32'h0a00_0002), .in_proto(in_proto), .in_sport(16'h1000),
    .in_dport(16'h2000), .in_iface(in_iface), .out_valid(out_valid), .out_ready(out_ready),
    .out_tag(out_tag), .out_len(out_len), .out_ds(out_ds), .out_grade(out_grade), .out_cond(out_cond));
  tdc_sink sink (.hclk(hclk), .hresetn(hresetn), .stall(stall), .out_valid(out_valid),
    .out_tag(out_tag), .out_ds(out_ds), .out_grade(out_grade), .out_cond(out_cond),
    .out_ready(out_ready), .rx_count(rx_count), .rx_tag(rx_tag), .rx_got(rx_got));
  ////////////////////////////////////////////////////////////
  // Clock and a hang guard
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // Values as they stand just before each rising edge
  always @(negedge hclk) begin
    rdy_n = hreadyout;
    ir_n = in_ready;
    rd_n = hrdata;
  end
  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One AHB single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge hclk);
    while (rdy_n !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (rdy_n !== 1'b1) @(posedge hclk);
    r = rd_n;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    chk(r, exp);
  endtask : rc
  // Present one descriptor and hold it until taken
  task automatic send(input logic [15:0] tag, input logic [15:0] len, input logic [7:0] ds,
                      input logic [7:0] proto);
    @(posedge hclk);
    in_valid <= 1'b1;
    in_tag <= tag;
    in_len <= len;
    in_ds <= ds;
    in_proto <= proto;
    in_iface <= tag[3:0];
    @(posedge hclk);
    while (ir_n !== 1'b1) @(posedge hclk);
    in_valid <= 1'b0;
  endtask : send
  // Wait for the n-th delivery, compare {cond, grade, ds} under a mask
  task automatic rx(input int n, input logic [10:0] exp, input logic [10:0] m);
    for (int i = 0; i < 40 && rx_count != n; i++) @(negedge hclk);
    chk(rx_count, n);
    chk(rx_got & m, exp);
  endtask : rx
  task automatic quiet(input int n);
    repeat (10) @(negedge hclk);
    chk(rx_count, n);
  endtask : quiet
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({hresp, hreadyout, irq, out_valid, in_ready}, 5'b01001);
    rc(TDC_CTRL, TDC_REG_RST);
    rc(TDC_STATUS, TDC_REG_RST);
    wr(8'h40, 32'hffff_ffff);
    rc(8'h40, 32'h0000_0000);
    // Codepoint classifier with no profile
    wr(TDC_MAP_LO, 32'h0000_0020);
    wr(TDC_MARK, 32'h000a_123f);
    wr(TDC_IRQ_MASK, 32'h0000_0004);
    send(1, 60, 8'h15, 6);
    rx(1, {1'b1, TDC_GR_IN, 8'hfd}, NOG);
    send(2, 60, 8'h1d, 6);
    rx(2, {1'b0, TDC_GR_IN, 8'h01}, NOG);
    // Header field classifier on protocol
    wr(TDC_HDR_MISC, 32'h0800_0011);
    wr(TDC_CTRL, 32'h0000_0001);
    send(3, 60, 8'h1d, 17);
    rx(3, {1'b1, TDC_GR_IN, 8'hfd}, NOG);
    send(4, 60, 8'h1d, 6);
    rx(4, {1'b0, TDC_GR_IN, 8'h01}, NOG);
    // Meter with drop action
    wr(TDC_CTRL, 32'h0000_0012);
    wr(TDC_BURST, 32'h0000_0064);
    wr(TDC_RATE, 32'h0000_0064);
    wr(TDC_RATE, 32'h0000_0000);
    rc(TDC_STATUS, 32'h0000_0064);
    send(5, 60, 8'h15, 6);
    rx(5, {1'b1, TDC_GR_IN, 8'h15}, ALL);
    rc(TDC_STATUS, 32'h0000_0028);
    send(6, 60, 8'h15, 6);
    quiet(5);
    chk(irq, 1'b1);
    rc(TDC_IRQ_STAT, 32'h0000_0004);
    wr(TDC_IRQ_STAT, 32'h0000_0004);
    rc(TDC_IRQ_STAT, 32'h0000_0000);
    @(negedge hclk);
    chk(irq, 1'b0);
    // Remark by grade, in and out
    wr(TDC_CTRL, 32'h0000_00e2);
    send(7, 60, 8'h15, 6);
    rx(6, {1'b1, TDC_GR_OUT, 8'h29}, ALL);
    send(8, 20, 8'h15, 6);
    rx(7, {1'b1, TDC_GR_IN, 8'h49}, ALL);
    // Pass with accounting, masked interrupt
    wr(TDC_CTRL, 32'h0000_0032);
    send(9, 60, 8'h15, 6);
    rx(8, {1'b1, TDC_GR_OUT, 8'h15}, ALL);
    rc(TDC_IRQ_STAT, 32'h0000_0001);
    @(negedge hclk);
    chk(irq, 1'b0);
    wr(TDC_IRQ_STAT, 32'h0000_0001);
    // Shaper of one slot: hold one, drop the next, release on refill
    wr(TDC_CTRL, 32'h0000_0102);
    send(10, 60, 8'h15, 6);
    send(11, 60, 8'h15, 6);
    quiet(8);
    rc(TDC_STATUS, 32'h0100_0014);
    rc(TDC_IRQ_STAT, 32'h0000_0002);
    wr(TDC_RATE, 32'h0000_0064);
    rx(9, {1'b1, TDC_GR_IN, 8'h15}, ALL);
    chk(rx_tag, 32'h0000_000a);
    wr(TDC_RATE, 32'h0000_0000);
    // Middle grade
    wr(TDC_CTRL, 32'h0000_0036);
    send(12, 150, 8'h15, 6);
    rx(10, {1'b1, TDC_GR_MID, 8'h15}, ALL);
    // Downstream stall holds the stream
    wr(TDC_CTRL, 32'h0000_0000);
    stall <= 1'b1;
    send(13, 60, 8'h15, 6);
    repeat (3) @(negedge hclk);
    chk({in_ready, out_valid}, 2'b01);
    chk({out_tag, out_len}, 32'h000d_003c);
    @(posedge hclk);
    stall <= 1'b0;
    rx(11, {1'b1, TDC_GR_IN, 8'hfd}, NOG);
    // Header rule with every field enabled, then an empty rule
    wr(TDC_CTRL, 32'h0000_0001);
    wr(TDC_HDR_SRC, 32'h0a00_0001);
    wr(TDC_HDR_DST, 32'h0a00_0002);
    wr(TDC_HDR_PORTS, 32'h1000_2000);
    wr(TDC_HDR_MISC, 32'h7f05_0e11);
    send(14, 60, 8'h15, 17);
    rx(12, {1'b1, TDC_GR_IN, 8'hfd}, NOG);
    send(15, 60, 8'h15, 17);
    rx(13, {1'b0, TDC_GR_IN, 8'h15}, NOG);
    wr(TDC_HDR_MISC, 32'h0000_0000);
    send(16, 60, 8'h1d, 6);
    rx(14, {1'b1, TDC_GR_IN, 8'hfd}, NOG);
    wrap_up();
  end
endmodule : diffserv_traffic_conditioner_tb_top
`default_nettype wire

// [tb/tdc_sink.sv]
// Downstream forwarding stage model for the traffic conditioner.
// Assumes descriptors arrive on hclk with a valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none
module tdc_sink (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [15:0] out_tag,
  input wire logic [7:0] out_ds,
  input wire tdc_pkg::tdc_grade_t out_grade,
  input wire logic out_cond,
  output logic out_ready,
  output int rx_count,
  output logic [15:0] rx_tag,
  output logic [10:0] rx_got
);
  import tdc_pkg::*;
  ////////////////////////////////////////////////////////////
  // Accept unless stalled; latch each accepted descriptor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ready <= 1'b1;
      rx_count <= 0;
      rx_tag <= 16'h0000;
      rx_got <= 11'h000;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) begin
        rx_count <= rx_count + 1;
        rx_tag <= out_tag;
        rx_got <= {out_cond, out_grade, out_ds};
      end
    end
  end
endmodule : tdc_sink
`default_nettype wire
